//--- hdl/cmcd_pkg.sv
// Overview of operation
// - Bytes 0F 40 plus a ModR/M byte decode as move when overflow, one clock, flags untouched.
// - Bytes 0F 41 plus a ModR/M byte decode as move when no overflow, one clock, no flags.
// - Bytes 0F 4A plus a ModR/M byte decode as move when parity even, one clock, no flags.
// - Bytes 0F 48 and 0F 49 decode as move when negative and nonnegative, one clock, no flags.
// - 0F B0 and 0F B1 are compare swap by width, any mod (mod 11 flagged as register form), six clocks, flags set.
// - Bytes 0F C7 with reg field 001 decode as eight byte compare swap, one clock, no flags.
package cmcd_pkg;
  localparam logic [7:0] ESCAPE = 8'h0f;
  localparam logic [7:0] OP_OVF = 8'h40;
  localparam logic [7:0] OP_NOVF = 8'h41;
  localparam logic [7:0] OP_NEG = 8'h48;
  localparam logic [7:0] OP_NNEG = 8'h49;
  localparam logic [7:0] OP_PAR = 8'h4a;
  localparam logic [6:0] OP_SWAP_HI = 7'h58;
  localparam logic [7:0] OP_SWAP8 = 8'hc7;
  localparam logic [2:0] SWAP8_REG = 3'h1;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam int MOD_POS = 6;
  localparam int REG_POS = 3;
  localparam logic [3:0] CYC_MOVE = 4'h1;
  localparam logic [3:0] CYC_SWAP = 4'h6;
  localparam logic [3:0] CYC_SWAP8 = 4'h1;
  localparam int FLAG_OVF = 3;
  localparam int FLAG_SIGN = 2;
  localparam int FLAG_PAR = 1;

  typedef enum {
    OP_NONE, OP_MOVE_WHEN_OVERFLOW, OP_MOVE_WHEN_NO_OVERFLOW, OP_MOVE_WHEN_PARITY_EVEN,
    OP_MOVE_WHEN_NEGATIVE, OP_MOVE_WHEN_NONNEGATIVE, OP_COMPARE_SWAP,
    OP_COMPARE_SWAP_EIGHT_BYTE
  } cmcd_op_e;

  typedef enum {ST_IDLE, ST_ESC, ST_OPC, ST_BUSY} cmcd_state_e;

  typedef struct packed {
    logic valid;
    logic [2:0] op;
    logic wide;
    logic regForm;
    logic [2:0] regField;
    logic [2:0] rmField;
    logic writeDest;
    logic flagsWrite;
  } cmcd_issue_s;

  typedef struct packed {
    cmcd_state_e state;
    logic [7:0] opcode;
    logic [3:0] count;
    cmcd_issue_s issue;
    logic busy;
  } cmcd_state_s;
endpackage

//--- hdl/cmcd_decode.sv
`timescale 1ns/1ps
module cmcd_decode (
  input wire logic clock,
  input wire logic rstn,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic [3:0] flags,
  output logic byteReady,
  output logic issueValid,
  output logic [2:0] issueOp,
  output logic issueWide,
  output logic issueRegForm,
  output logic [2:0] issueReg,
  output logic [2:0] issueRm,
  output logic issueWriteDest,
  output logic issueFlagsWrite,
  output logic done
);
  cmcd_pkg::cmcd_state_s s_q, s_d;
  logic condHold;
  logic known;
  logic [2:0] opSel;
  logic [3:0] cycles;

  // Opcode classification
  always_comb begin
    known = 1'b1;
    opSel = 3'(cmcd_pkg::OP_NONE);
    cycles = cmcd_pkg::CYC_MOVE;
    condHold = 1'b0;
    if (s_q.opcode == cmcd_pkg::OP_OVF) begin
      opSel = 3'(cmcd_pkg::OP_MOVE_WHEN_OVERFLOW);
      condHold = flags[cmcd_pkg::FLAG_OVF];
    end else if (s_q.opcode == cmcd_pkg::OP_NOVF) begin
      opSel = 3'(cmcd_pkg::OP_MOVE_WHEN_NO_OVERFLOW);
      condHold = !flags[cmcd_pkg::FLAG_OVF];
    end else if (s_q.opcode == cmcd_pkg::OP_PAR) begin
      opSel = 3'(cmcd_pkg::OP_MOVE_WHEN_PARITY_EVEN);
      condHold = flags[cmcd_pkg::FLAG_PAR];
    end else if (s_q.opcode == cmcd_pkg::OP_NEG) begin
      opSel = 3'(cmcd_pkg::OP_MOVE_WHEN_NEGATIVE);
      condHold = flags[cmcd_pkg::FLAG_SIGN];
    end else if (s_q.opcode == cmcd_pkg::OP_NNEG) begin
      opSel = 3'(cmcd_pkg::OP_MOVE_WHEN_NONNEGATIVE);
      condHold = !flags[cmcd_pkg::FLAG_SIGN];
    end else if (s_q.opcode[7:1] == cmcd_pkg::OP_SWAP_HI) begin
      opSel = 3'(cmcd_pkg::OP_COMPARE_SWAP);
      cycles = cmcd_pkg::CYC_SWAP;
    end else if (s_q.opcode == cmcd_pkg::OP_SWAP8 &&
                 byteData[cmcd_pkg::REG_POS +: 3] == cmcd_pkg::SWAP8_REG) begin
      opSel = 3'(cmcd_pkg::OP_COMPARE_SWAP_EIGHT_BYTE);
      cycles = cmcd_pkg::CYC_SWAP8;
    end else begin
      known = 1'b0;
    end
  end

  // Sequencer
  always_comb begin
    s_d = s_q;
    s_d.issue.valid = 1'b0;
    case (s_q.state)
      cmcd_pkg::ST_IDLE: begin
        if (byteValid && byteData == cmcd_pkg::ESCAPE) begin
          s_d.state = cmcd_pkg::ST_ESC;
        end
      end
      cmcd_pkg::ST_ESC: begin
        if (byteValid) begin
          s_d.opcode = byteData;
          s_d.state = cmcd_pkg::ST_OPC;
        end
      end
      cmcd_pkg::ST_OPC: begin
        if (byteValid) begin
          if (known) begin
            s_d.issue.valid = 1'b1;
            s_d.issue.op = opSel;
            s_d.issue.wide = s_q.opcode[0];
            s_d.issue.regForm = byteData[cmcd_pkg::MOD_POS +: 2] == cmcd_pkg::MOD_REG;
            s_d.issue.regField = byteData[cmcd_pkg::REG_POS +: 3];
            s_d.issue.rmField = byteData[2:0];
            s_d.issue.writeDest = condHold;
            s_d.issue.flagsWrite = opSel == 3'(cmcd_pkg::OP_COMPARE_SWAP);
            s_d.count = cycles - 4'h1;
            s_d.busy = 1'b1;
            s_d.state = cmcd_pkg::ST_BUSY;
          end else begin
            s_d.state = cmcd_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        if (s_q.count == 4'h0) begin
          s_d.busy = 1'b0;
          s_d.state = cmcd_pkg::ST_IDLE;
        end else begin
          s_d.count = s_q.count - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign byteReady = s_q.state != cmcd_pkg::ST_BUSY;
  assign issueValid = s_q.issue.valid;
  assign issueOp = s_q.issue.op;
  assign issueWide = s_q.issue.wide;
  assign issueRegForm = s_q.issue.regForm;
  assign issueReg = s_q.issue.regField;
  assign issueRm = s_q.issue.rmField;
  assign issueWriteDest = s_q.issue.writeDest;
  assign issueFlagsWrite = s_q.issue.flagsWrite;
  assign done = s_q.busy && s_q.count == 4'h0;

  sequence moveIssued;
    issueValid && issueOp != 3'(cmcd_pkg::OP_COMPARE_SWAP);
  endsequence
  sequence swapIssued;
    issueValid && issueOp == 3'(cmcd_pkg::OP_COMPARE_SWAP);
  endsequence

  AST_MOVE_ONE: assert property (@(posedge clock) disable iff (!rstn)
    moveIssued |-> done)
    else $error("move did not finish in one clock");
  AST_SWAP_SIX: assert property (@(posedge clock) disable iff (!rstn)
    swapIssued |-> !done [*5] ##1 done)
    else $error("compare swap did not take six clocks");
  AST_SWAP_FLAGS: assert property (@(posedge clock) disable iff (!rstn)
    issueValid |-> issueFlagsWrite == (issueOp == 3'(cmcd_pkg::OP_COMPARE_SWAP)))
    else $error("flag write wrong");
  AST_OVF_DECODE: assert property (@(posedge clock) disable iff (!rstn)
    $past(s_q.state) == cmcd_pkg::ST_OPC && $past(byteValid) &&
    $past(s_q.opcode) == cmcd_pkg::OP_OVF |-> issueValid &&
    issueWriteDest == $past(flags[cmcd_pkg::FLAG_OVF]))
    else $error("overflow move misdecoded");
  AST_NOVF_DECODE: assert property (@(posedge clock) disable iff (!rstn)
    issueValid && issueOp == 3'(cmcd_pkg::OP_MOVE_WHEN_NO_OVERFLOW) |->
    issueWriteDest == !$past(flags[cmcd_pkg::FLAG_OVF]))
    else $error("no overflow move misdecoded");
  AST_PAR_DECODE: assert property (@(posedge clock) disable iff (!rstn)
    issueValid && issueOp == 3'(cmcd_pkg::OP_MOVE_WHEN_PARITY_EVEN) |->
    issueWriteDest == $past(flags[cmcd_pkg::FLAG_PAR]))
    else $error("parity move misdecoded");
  AST_SIGN_DECODE: assert property (@(posedge clock) disable iff (!rstn)
    issueValid && issueOp == 3'(cmcd_pkg::OP_MOVE_WHEN_NEGATIVE) |->
    issueWriteDest == $past(flags[cmcd_pkg::FLAG_SIGN]))
    else $error("sign move misdecoded");
  AST_SWAP8_REG: assert property (@(posedge clock) disable iff (!rstn)
    issueValid && issueOp == 3'(cmcd_pkg::OP_COMPARE_SWAP_EIGHT_BYTE) |->
    issueReg == cmcd_pkg::SWAP8_REG)
    else $error("eight byte swap with wrong reg field");
  AST_NO_WRITE_SWAP: assert property (@(posedge clock) disable iff (!rstn)
    issueValid && !issueFlagsWrite && !issueWriteDest |-> done)
    else $error("false move skipped its clock");

  // Steps of a taken instruction
  sequence modrmTaken;
    s_q.state == cmcd_pkg::ST_OPC && byteValid;
  endsequence
  sequence moveExecute;
    !byteReady ##1 byteReady;
  endsequence
  sequence swapExecute;
    !byteReady [*6] ##1 byteReady;
  endsequence

  // Decode checks
  AST_NOVF_ISSUE: assert property (@(posedge clock) disable iff (!rstn)
    modrmTaken ##0 (s_q.opcode == cmcd_pkg::OP_NOVF) |=>
    issueValid && issueOp == 3'(cmcd_pkg::OP_MOVE_WHEN_NO_OVERFLOW))
    else $error("no overflow move not issued");
  AST_PAR_ISSUE: assert property (@(posedge clock) disable iff (!rstn)
    modrmTaken ##0 (s_q.opcode == cmcd_pkg::OP_PAR) |=>
    issueValid && issueOp == 3'(cmcd_pkg::OP_MOVE_WHEN_PARITY_EVEN))
    else $error("parity move not issued");
  AST_NEG_ISSUE: assert property (@(posedge clock) disable iff (!rstn)
    modrmTaken ##0 (s_q.opcode == cmcd_pkg::OP_NEG) |=>
    issueValid && issueOp == 3'(cmcd_pkg::OP_MOVE_WHEN_NEGATIVE))
    else $error("negative move not issued");
  AST_NNEG_ISSUE: assert property (@(posedge clock) disable iff (!rstn)
    modrmTaken ##0 (s_q.opcode == cmcd_pkg::OP_NNEG) |=>
    issueValid && issueOp == 3'(cmcd_pkg::OP_MOVE_WHEN_NONNEGATIVE))
    else $error("nonnegative move not issued");
  AST_NNEG_DECODE: assert property (@(posedge clock) disable iff (!rstn)
    issueValid && issueOp == 3'(cmcd_pkg::OP_MOVE_WHEN_NONNEGATIVE) |->
    issueWriteDest == !$past(flags[cmcd_pkg::FLAG_SIGN]))
    else $error("nonnegative move misdecoded");
  AST_SWAP_ISSUE: assert property (@(posedge clock) disable iff (!rstn)
    modrmTaken ##0 (s_q.opcode[7:1] == cmcd_pkg::OP_SWAP_HI) |=>
    issueValid && issueOp == 3'(cmcd_pkg::OP_COMPARE_SWAP) &&
    issueWide == $past(s_q.opcode[0]) &&
    issueRegForm == ($past(byteData[cmcd_pkg::MOD_POS +: 2]) == cmcd_pkg::MOD_REG))
    else $error("compare swap misdecoded");
  AST_SWAP8_ISSUE: assert property (@(posedge clock) disable iff (!rstn)
    modrmTaken ##0 (s_q.opcode == cmcd_pkg::OP_SWAP8) ##0
    (byteData[cmcd_pkg::REG_POS +: 3] == cmcd_pkg::SWAP8_REG) |=>
    issueValid && issueOp == 3'(cmcd_pkg::OP_COMPARE_SWAP_EIGHT_BYTE))
    else $error("eight byte swap not issued");
  AST_SWAP8_REFUSE: assert property (@(posedge clock) disable iff (!rstn)
    modrmTaken ##0 (s_q.opcode == cmcd_pkg::OP_SWAP8) ##0
    (byteData[cmcd_pkg::REG_POS +: 3] != cmcd_pkg::SWAP8_REG) |=> !issueValid)
    else $error("eight byte swap issued with wrong reg field");
  AST_MOVE_NO_FLAGS: assert property (@(posedge clock) disable iff (!rstn)
    moveIssued |-> !issueFlagsWrite)
    else $error("move asked for a flag write");

  // Timing checks
  AST_ISSUE_PULSE: assert property (@(posedge clock) disable iff (!rstn)
    issueValid |=> !issueValid)
    else $error("issue lasted more than one clock");
  AST_MOVE_BUSY: assert property (@(posedge clock) disable iff (!rstn)
    moveIssued |-> moveExecute)
    else $error("move did not hold off the next byte for one clock");
  AST_SWAP_BUSY: assert property (@(posedge clock) disable iff (!rstn)
    swapIssued |-> swapExecute)
    else $error("compare swap did not hold off the next byte for six clocks");
  AST_DEST_HOLD: assert property (@(posedge clock) disable iff (!rstn)
    !issueValid |-> $stable(issueWriteDest))
    else $error("destination write changed without an issue");
endmodule

//--- verif/cmcd_fetch_model.sv
`timescale 1ns/1ps
module cmcd_fetch_model (
  input wire logic clock,
  input wire logic byteReady,
  output logic byteValid,
  output logic [7:0] byteData
);
  initial begin
    byteValid = 1'b0;
    byteData = 8'h00;
  end
  // Offers escape, opcode, ModR/M; each byte held until taken, giving up with ok low after 20 clocks
  task automatic sendInstr(input logic [7:0] opc, input logic [7:0] mrm, output logic ok);
    logic [7:0] seq [3];
    int i;
    int n;
    seq = '{8'h0f, opc, mrm};
    ok = 1'b1;
    for (i = 0; i < 3 && ok; i++) begin
      byteValid <= 1'b1;
      byteData <= seq[i];
      ok = 1'b0;
      for (n = 0; n < 20 && !ok; n++) begin
        @(negedge clock);
        ok = byteReady;
        @(posedge clock);
      end
    end
    byteValid <= 1'b0;
    byteData <= ~mrm;
  endtask
endmodule

//--- verif/cmcd_decode_tb.sv
`timescale 1ns/1ps
module cmcd_decode_tb;
  logic clock;
  logic rstn;
  logic byteValid;
  logic [7:0] byteData;
  logic [3:0] flags;
  logic byteReady, issueValid, issueWide, issueRegForm, issueWriteDest, issueFlagsWrite, done;
  logic [2:0] issueOp, issueReg, issueRm;
  logic [31:0] rnd;
  logic [7:0] opcTab [10];
  logic [7:0] opc;
  logic [7:0] mrm;
  logic [2:0] e;
  logic ok;
  int badCount;
  int totalChecks;
  int n;
  cmcd_decode dut (.clock(clock), .rstn(rstn), .byteValid(byteValid), .byteData(byteData),
    .flags(flags), .byteReady(byteReady), .issueValid(issueValid), .issueOp(issueOp),
    .issueWide(issueWide), .issueRegForm(issueRegForm), .issueReg(issueReg), .issueRm(issueRm),
    .issueWriteDest(issueWriteDest), .issueFlagsWrite(issueFlagsWrite), .done(done));
  cmcd_fetch_model fetch (.clock(clock), .byteReady(byteReady), .byteValid(byteValid),
    .byteData(byteData));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [2:0] expOp(input logic [7:0] o, input logic [7:0] m);
    case (o)
      8'h40: return 3'h1;
      8'h41: return 3'h2;
      8'h4a: return 3'h3;
      8'h48: return 3'h4;
      8'h49: return 3'h5;
      8'hb0, 8'hb1: return 3'h6;
      8'hc7: return (m[5:3] == 3'h1) ? 3'h7 : 3'h0;
      default: return 3'h0;
    endcase
  endfunction
  function automatic logic expWr(input logic [2:0] op, input logic [3:0] f);
    case (op)
      3'h1: return f[3];
      3'h2: return !f[3];
      3'h3: return f[1];
      3'h4: return f[2];
      3'h5: return !f[2];
      default: return 1'b0;
    endcase
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    badCount = 0;
    totalChecks = 0;
    rnd = 32'h0bec;
    flags = 4'h0;
    rstn = 1'b0;
    opcTab = '{8'h40, 8'h41, 8'h4a, 8'h48, 8'h49, 8'hb0, 8'hb1, 8'hc7, 8'hc7, 8'ha2};
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    for (int t = 0; t < 60; t++) begin
      @(posedge clock);
      rnd = xs(rnd);
      opc = opcTab[t < 10 ? t : rnd[31:8] % 10];
      mrm = rnd[15:8];
      if (t < 9 || opc == 8'hc7) mrm[5:3] = (t == 8) ? 3'h3 : 3'h1;
      if (t == 5) mrm[7:6] = 2'h3;
      flags <= rnd[3:0];
      fetch.sendInstr(opc, mrm, ok);
      if (!ok) begin
        chk("byte taken", 16'h0, 16'h1);
        endOfTest();
      end
      @(negedge clock);
      e = expOp(opc, mrm);
      if (e == 3'h0) chk("no issue", issueValid, 16'h0);
      else begin
        chk("issue", {issueValid, issueOp, issueWide, issueRegForm, issueReg, issueRm,
          issueWriteDest, issueFlagsWrite}, {1'b1, e, opc[0], mrm[7:6] == 2'h3, mrm[5:3],
          mrm[2:0], expWr(e, rnd[3:0]), e == 3'h6});
        chk("ready at issue", byteReady, 16'h0);
        for (n = 0; n < 12 && done !== 1'b1; n++) @(negedge clock);
        chk("latency", n[15:0], e == 3'h6 ? 16'h5 : 16'h0);
        if (n == 12) endOfTest();
      end
      $display("test %0d opcode %h done", t, opc);
    end
    endOfTest();
  end
endmodule
